/* File: rtl/bsf_datapath.sv */
/*
  bsf_datapath: stack push and pop, i/o bit set and clear, shifts and
  rotates, nibble swap, transfer-flag bit moves and flag set and clear.
  assumes the core presents one op with start for one cycle while busy
  is low, and that register file, stack and i/o space answer reads
  combinationally in the cycle their read strobe is high.
*/
`timescale 1ns/10ps
module bsf_datapath
  import bsf_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // operation request
  input  wire logic              start,
  input  wire bsf_op_t           op,
  input  wire logic [REG_AW-1:0] reg_sel,
  input  wire logic [IO_AW-1:0]  io_addr,
  input  wire logic [2:0]        bit_sel,
  output logic                   busy,
  output logic                   done,
  // working register file
  output logic                   rf_rd,
  output logic [REG_AW-1:0]      rf_addr,
  input  wire logic [DATA_W-1:0] rf_rdata,
  output logic                   rf_we,
  output logic [DATA_W-1:0]      rf_wdata,
  // stack
  output logic                   stk_push,
  output logic                   stk_pop,
  output logic [DATA_W-1:0]      stk_wdata,
  input  wire logic [DATA_W-1:0] stk_rdata,
  // i/o space
  output logic                   io_rd,
  output logic                   io_we,
  output logic [IO_AW-1:0]       io_addr_o,
  input  wire logic [DATA_W-1:0] io_rdata,
  output logic [DATA_W-1:0]      io_wdata,
  // status flags
  output logic [DATA_W-1:0]      status_flags_reg
);

  typedef enum logic [1:0] {ST_IDLE, ST_SECOND} bsf_state_t;

  typedef struct packed {
    bsf_state_t        st;
    bsf_op_t           op;
    logic [REG_AW-1:0] reg_sel;
    logic [IO_AW-1:0]  io_addr;
    logic [2:0]        bit_sel;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] flags;
    logic              done;
    logic              rf_we;
    logic              stk_push;
    logic              io_we;
  } bsf_regs_t;

  bsf_regs_t r_q;
  bsf_regs_t r_d;
  logic      rst_n;
  logic      first_rd;
  logic      ok;

  bsf_shift_if sh ();

  bsf_reset_sync u_rst (
    .clk        (clk),
    .resetn     (resetn),
    .rst_sync_n (rst_n)
  );

  bsf_shift_unit u_shift (
    .sh (sh.unit)
  );

  assign ok          = start && (r_q.st == ST_IDLE);
  assign sh.op       = op;
  assign sh.operand  = rf_rdata;
  assign sh.carry_in = r_q.flags[FLAG_C];

  // first-cycle reads are combinational strobes
  always_comb begin
    first_rd = 1'b0;
    case (op)
      OP_PUSH, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_SAR, OP_SWAP,
      OP_TSTORE, OP_TLOAD: first_rd = 1'b1;
      default:        first_rd = 1'b0;
    endcase
  end

  assign busy      = (r_q.st != ST_IDLE);
  assign done      = r_q.done;
  assign rf_rd     = ok && first_rd;
  assign rf_addr   = r_q.rf_we ? r_q.reg_sel : reg_sel;
  assign rf_we     = r_q.rf_we;
  assign rf_wdata  = r_q.data;
  assign stk_push  = r_q.stk_push;
  assign stk_wdata = r_q.data;
  assign stk_pop   = ok && (op == OP_POP);
  assign io_rd     = ok && ((op == OP_IO_SET) || (op == OP_IO_CLR));
  assign io_we     = r_q.io_we;
  assign io_addr_o = r_q.io_we ? r_q.io_addr : io_addr;
  assign io_wdata  = r_q.data;
  assign status_flags_reg = r_q.flags;

  always_comb begin
    r_d          = r_q;
    r_d.done     = 1'b0;
    r_d.rf_we    = 1'b0;
    r_d.stk_push = 1'b0;
    r_d.io_we    = 1'b0;
    case (r_q.st)
      ST_IDLE: begin
        if (start) begin
          r_d.op      = op;
          r_d.reg_sel = reg_sel;
          r_d.io_addr = io_addr;
          r_d.bit_sel = bit_sel;
          r_d.flags   = r_q.flags;
          case (op)
            OP_PUSH: begin
              r_d.data = rf_rdata;
              r_d.st   = ST_SECOND;
            end
            OP_POP: begin
              r_d.data = stk_rdata;
              r_d.st   = ST_SECOND;
            end
            OP_IO_SET: begin
              r_d.data          = io_rdata;
              r_d.data[bit_sel] = 1'b1;
              r_d.st            = ST_SECOND;
            end
            OP_IO_CLR: begin
              r_d.data          = io_rdata;
              r_d.data[bit_sel] = 1'b0;
              r_d.st            = ST_SECOND;
            end
            OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_SAR: begin
              r_d.data         = sh.result;
              r_d.rf_we        = 1'b1;
              r_d.done         = 1'b1;
              r_d.flags[FLAG_C] = sh.carry_out;
              r_d.flags[FLAG_Z] = (sh.result == DATA_RST);
              r_d.flags[FLAG_N] = sh.result[DATA_W-1];
              r_d.flags[FLAG_V] = sh.result[DATA_W-1] ^ sh.carry_out;
            end
            OP_SWAP: begin
              r_d.data  = sh.result;
              r_d.rf_we = 1'b1;
              r_d.done  = 1'b1;
            end
            OP_TSTORE: begin
              r_d.flags[FLAG_T] = rf_rdata[bit_sel];
              r_d.done          = 1'b1;
            end
            OP_TLOAD: begin
              r_d.data          = rf_rdata;
              r_d.data[bit_sel] = r_q.flags[FLAG_T];
              r_d.rf_we         = 1'b1;
              r_d.done          = 1'b1;
            end
            OP_FLAG_SET: begin
              r_d.flags[bit_sel] = 1'b1;
              r_d.done           = 1'b1;
            end
            OP_FLAG_CLR: begin
              r_d.flags[bit_sel] = 1'b0;
              r_d.done           = 1'b1;
            end
            OP_VSET: begin
              r_d.flags[FLAG_V] = 1'b1;
              r_d.done          = 1'b1;
            end
            OP_VCLR: begin
              r_d.flags[FLAG_V] = 1'b0;
              r_d.done          = 1'b1;
            end
            OP_HSET: begin
              r_d.flags[FLAG_H] = 1'b1;
              r_d.done          = 1'b1;
            end
            OP_HCLR: begin
              r_d.flags[FLAG_H] = 1'b0;
              r_d.done          = 1'b1;
            end
            default: begin
              r_d.done = 1'b1;
            end
          endcase
        end
      end
      ST_SECOND: begin
        r_d.st   = ST_IDLE;
        r_d.done = 1'b1;
        case (r_q.op)
          OP_PUSH:              r_d.stk_push = 1'b1;
          OP_POP:               r_d.rf_we    = 1'b1;
          OP_IO_SET, OP_IO_CLR: r_d.io_we    = 1'b1;
          default:              r_d.done     = 1'b1;
        endcase
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{st: ST_IDLE, op: OP_NONE, reg_sel: '0, io_addr: '0,
               bit_sel: 3'h0, data: DATA_RST, flags: FLAGS_RST,
               done: 1'b0, rf_we: 1'b0, stk_push: 1'b0, io_we: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

endmodule : bsf_datapath

/* File: inc/bsf_pkg.sv */
/*
  bsf_pkg: shared constants and types for the bit, shift and flag datapath.
  assumes nothing beyond a systemverilog compiler.
*/
package bsf_pkg;

  localparam int DATA_W = 8;
  localparam int REG_AW = 5;
  localparam int IO_AW  = 6;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;

  // cycle counts
  localparam int CYC_TWO = 2;
  localparam int CYC_ONE = 1;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_PUSH,
    OP_POP,
    OP_IO_SET,
    OP_IO_CLR,
    OP_SHL,
    OP_SHR,
    OP_ROTL,
    OP_ROTR,
    OP_SAR,
    OP_SWAP,
    OP_TSTORE,
    OP_TLOAD,
    OP_FLAG_SET,
    OP_FLAG_CLR,
    OP_VSET,
    OP_VCLR,
    OP_HSET,
    OP_HCLR
  } bsf_op_t;

endpackage : bsf_pkg

/* File: inc/bsf_shift_if.sv */
/*
  bsf_shift_if: operand and result bundle between the sequencer and the
  shift unit.
  assumes both ends sit in the same clock domain.
*/
`timescale 1ns/10ps
interface bsf_shift_if;
  import bsf_pkg::*;

  bsf_op_t           op;
  logic [DATA_W-1:0] operand;
  logic              carry_in;
  logic [DATA_W-1:0] result;
  logic              carry_out;

  modport master (output op, output operand, output carry_in,
                  input result, input carry_out);
  modport unit   (input op, input operand, input carry_in,
                  output result, output carry_out);
endinterface : bsf_shift_if

/* File: rtl/bsf_shift_unit.sv */
/*
  bsf_shift_unit: combinational shift, rotate and nibble swap.
  assumes the caller registers the result and updates the flags.
*/
`timescale 1ns/10ps
module bsf_shift_unit
  import bsf_pkg::*;
(
  // operand and result
  bsf_shift_if.unit sh
);

  always_comb begin
    sh.result    = sh.operand;
    sh.carry_out = sh.carry_in;
    case (sh.op)
      OP_SHL: begin
        sh.result    = {sh.operand[DATA_W-2:0], 1'b0};
        sh.carry_out = sh.operand[DATA_W-1];
      end
      OP_SHR: begin
        sh.result    = {1'b0, sh.operand[DATA_W-1:1]};
        sh.carry_out = sh.operand[0];
      end
      OP_ROTL: begin
        sh.result    = {sh.operand[DATA_W-2:0], sh.carry_in};
        sh.carry_out = sh.operand[DATA_W-1];
      end
      OP_ROTR: begin
        sh.result    = {sh.carry_in, sh.operand[DATA_W-1:1]};
        sh.carry_out = sh.operand[0];
      end
      OP_SAR: begin
        sh.result    = {sh.operand[DATA_W-1], sh.operand[DATA_W-1:1]};
        sh.carry_out = sh.operand[0];
      end
      OP_SWAP: begin
        sh.result = {sh.operand[DATA_W/2-1:0], sh.operand[DATA_W-1:DATA_W/2]};
      end
      default: begin
        sh.result    = sh.operand;
        sh.carry_out = sh.carry_in;
      end
    endcase
  end

endmodule : bsf_shift_unit

/* File: rtl/bsf_reset_sync.sv */
/*
  bsf_reset_sync: two-flop release of the active-low reset.
  assumes resetn may assert at any time.
*/
`timescale 1ns/10ps
module bsf_reset_sync (
  // clock and raw reset
  input  wire logic clk,
  input  wire logic resetn,
  // synchronised reset
  output logic      rst_sync_n
);

  logic [1:0] sync_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= 2'h0;
    end else begin
      sync_q <= {sync_q[0], 1'b1};
    end
  end

  assign rst_sync_n = sync_q[1];

endmodule : bsf_reset_sync

/* File: verif/bsf_dp_asserts.sv */
/*
  bsf_dp_asserts: timing and result checks on the datapath ports.
  assumes one clock and the raw active-low reset.
*/
`timescale 1ns/10ps
module bsf_dp_asserts
  import bsf_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // request
  input wire logic              start,
  input wire bsf_op_t           op,
  input wire logic [2:0]        bit_sel,
  input wire logic              busy,
  input wire logic              done,
  // results
  input wire logic [DATA_W-1:0] rf_rdata,
  input wire logic              rf_we,
  input wire logic [DATA_W-1:0] rf_wdata,
  input wire logic              stk_push,
  input wire logic              io_we,
  input wire logic [DATA_W-1:0] io_wdata,
  input wire logic [DATA_W-1:0] status_flags_reg
);
  logic       go;
  logic [7:0] rd_q;
  logic [7:0] fl_q;
  logic [2:0] bs_q;
  assign go = start && !busy;
  always_ff @(posedge clk) begin
    rd_q <= rf_rdata;
    fl_q <= status_flags_reg;
    bs_q <= bit_sel;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence two_cyc;
    busy ##1 (done && !busy);
  endsequence
  sequence one_cyc;
    done && rf_we;
  endsequence
  push_two_cyc_a: assert property (
    go && op == OP_PUSH |=> two_cyc ##0 stk_push) else $error("push late");
  pop_two_cyc_a: assert property (
    go && op == OP_POP |=> two_cyc ##0 rf_we) else $error("pop late");
  io_bit_set_a: assert property (
    go && op == OP_IO_SET |=> two_cyc ##0 (io_we
    && io_wdata[$past(bit_sel, 2)])) else $error("io set wrong");
  io_bit_clr_a: assert property (
    go && op == OP_IO_CLR |=> two_cyc ##0 (io_we
    && !io_wdata[$past(bit_sel, 2)])) else $error("io clear wrong");
  shl_result_a: assert property (
    go && op == OP_SHL |=> one_cyc ##0 rf_wdata == {rd_q[6:0], 1'b0}
    && status_flags_reg[0] == rd_q[7]) else $error("shift left wrong");
  shr_result_a: assert property (
    go && op == OP_SHR |=> one_cyc ##0 rf_wdata == {1'b0, rd_q[7:1]}
    && status_flags_reg[0] == rd_q[0]) else $error("shift right wrong");
  rotl_carry_a: assert property (
    go && op == OP_ROTL |=> one_cyc ##0 rf_wdata == {rd_q[6:0], fl_q[0]})
    else $error("rotate left wrong");
  sar_sign_a: assert property (
    go && op == OP_SAR |=> one_cyc ##0 rf_wdata == {rd_q[7], rd_q[7:1]})
    else $error("arith shift wrong");
  swap_flags_a: assert property (
    go && op == OP_SWAP |=> rf_wdata == {rd_q[3:0], rd_q[7:4]}
    && $stable(status_flags_reg)) else $error("swap wrong");
  tstore_only_a: assert property (
    go && op == OP_TSTORE |=> status_flags_reg
    == {fl_q[7], rd_q[bs_q], fl_q[5:0]}) else $error("bit store wrong");
  vset_only_a: assert property (
    go && op == OP_VSET |=> status_flags_reg == (fl_q | 8'h08))
    else $error("overflow set wrong");
  hclr_only_a: assert property (
    go && op == OP_HCLR |=> status_flags_reg == (fl_q & 8'hdf))
    else $error("half carry clear wrong");
endmodule : bsf_dp_asserts

/* File: verif/tb_top.sv */
/*
  tb_top: directed test of the bit, shift and flag datapath.
  assumes rf, stack and i/o read data are answered by the bench.
*/
`timescale 1ns/10ps
module tb_top;
  import bsf_pkg::*;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       start = 1'b0;
  bsf_op_t    op = OP_NONE;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] rdat = 8'h00;
  logic       busy, done, rf_we, stk_push, io_we, rf_rd, stk_pop, io_rd;
  logic [4:0] rf_addr;
  logic [5:0] io_addr_o;
  logic [7:0] rf_wdata, stk_wdata, io_wdata, flags, ef, d;
  logic [8:0] r;
  int         miscompares = 0;
  int         cmp_count = 0;
  bsf_op_t    sh_ops [5] = '{OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_SAR};
  always #5 clk = ~clk;
  bsf_datapath DUT (.clk, .resetn, .start, .op, .reg_sel(5'h0b),
    .io_addr(6'h2a), .bit_sel, .busy, .done, .rf_rd, .rf_addr,
    .rf_rdata(rdat), .rf_we, .rf_wdata, .stk_push, .stk_pop,
    .stk_wdata, .stk_rdata(rdat), .io_rd, .io_we, .io_addr_o,
    .io_rdata(rdat), .io_wdata, .status_flags_reg(flags));
  function logic [8:0] shf(bsf_op_t o, logic [7:0] x, logic c);
    case (o)
      OP_SHL:  return {x[7], x[6:0], 1'b0};
      OP_SHR:  return {x[0], 1'b0, x[7:1]};
      OP_ROTL: return {x[7], x[6:0], c};
      OP_ROTR: return {x[0], c, x[7:1]};
      default: return {x[0], x[7], x[7:1]};
    endcase
  endfunction : shf
  task chk(logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  // start stays high through busy, so a refused start is also exercised
  task run(bsf_op_t o, logic [7:0] x, logic [2:0] b, int n);
    @(negedge clk);
    start = 1'b1;
    op = o;
    rdat = x;
    bit_sel = b;
    #1;
    chk({4'h0, busy, rf_rd, stk_pop, io_rd}, {5'h0, !(o inside {OP_POP,
      OP_IO_SET, OP_IO_CLR, OP_VSET, OP_VCLR, OP_HSET, OP_HCLR,
      OP_FLAG_SET, OP_FLAG_CLR}), o == OP_POP,
      o == OP_IO_SET || o == OP_IO_CLR});
    repeat (n) @(negedge clk);
    start = 1'b0;
    chk({7'h0, done}, 8'h01);
    if (n == 2) chk({5'h0, stk_push, rf_we, io_we}, {5'h0,
      o == OP_PUSH, o == OP_POP, o == OP_IO_SET || o == OP_IO_CLR});
  endtask : run
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #50us;
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
    ef = 8'h00;
    chk(flags, ef);
    run(OP_VSET, 8'h00, 3'h0, 1);
    chk(flags, 8'h08);
    run(OP_HSET, 8'h00, 3'h0, 1);
    chk(flags, 8'h28);
    run(OP_VCLR, 8'h00, 3'h0, 1);
    chk(flags, 8'h20);
    run(OP_HCLR, 8'h00, 3'h0, 1);
    chk(flags, 8'h00);
    run(OP_FLAG_SET, 8'h00, 3'h4, 1);
    chk(flags, 8'h10);
    run(OP_FLAG_CLR, 8'h00, 3'h4, 1);
    chk(flags, 8'h00);
    foreach (sh_ops[i]) for (int k = 0; k < 2; k++) begin
      d = k ? 8'h80 : 8'h01;
      r = shf(sh_ops[i], d, ef[0]);
      run(sh_ops[i], d, 3'h0, 1);
      ef[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
      chk(rf_wdata, r[7:0]);
      chk(flags, ef);
    end
    run(OP_SWAP, 8'h3c, 3'h0, 1);
    chk(rf_wdata, 8'hc3);
    chk(flags, ef);
    run(OP_TSTORE, 8'h08, 3'h3, 1);
    ef[FLAG_T] = 1'b1;
    chk(flags, ef);
    run(OP_TLOAD, 8'hf0, 3'h0, 1);
    chk(rf_wdata, 8'hf1);
    chk(flags, ef);
    run(OP_PUSH, 8'ha5, 3'h0, 2);
    chk(stk_wdata, 8'ha5);
    chk(flags, ef);
    @(negedge clk);
    chk({7'h0, done}, 8'h00);
    run(OP_POP, 8'h5a, 3'h0, 2);
    chk(rf_wdata, 8'h5a);
    chk({3'h0, rf_addr}, 8'h0b);
    run(OP_IO_SET, 8'h10, 3'h2, 2);
    chk(io_wdata, 8'h14);
    chk({2'h0, io_addr_o}, 8'h2a);
    run(OP_IO_CLR, 8'h14, 3'h4, 2);
    chk(io_wdata, 8'h04);
    chk(flags, ef);
    give_verdict;
  end
endmodule : tb_top
bind bsf_datapath bsf_dp_asserts u_chk (.clk, .resetn, .start, .op,
  .bit_sel, .busy, .done, .rf_rdata, .rf_we, .rf_wdata, .stk_push,
  .io_we, .io_wdata, .status_flags_reg);
